// File: hw/ptalm_sync.sv
// Purpose: two-stage synchroniser with falling edge pulse
// Assumes: input is asynchronous to aclk
// Notes: edge detect looks only at the second stage and later
`timescale 1ns/1ps
`default_nettype none
module ptalm_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic async_i,
  output logic level_o,
  output logic fall_o
);
  logic meta_r;
  logic sync_r;
  logic prev_r;
  logic [1:0] fill_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      prev_r <= 1'b1;
      fill_r <= 2'h0;
      fall_o <= 1'b0;
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
      prev_r <= sync_r;
      // no edge until every stage holds a sampled value, so reset fakes none
      if (!(&fill_r)) begin
        fill_r <= fill_r + 2'h1;
      end
      fall_o <= (&fill_r) & prev_r & ~sync_r;
    end
  end

  assign level_o = prev_r;
endmodule : ptalm_sync
`default_nettype wire

// File: hw/ptalm_tick_gen.sv
// Purpose: source clock ticks for the countdown
// Assumes: minute_i is a one-cycle pulse from the calendar on aclk
// Notes: 32.768 kHz oscillator is emulated by an aclk prescaler
`timescale 1ns/1ps
`default_nettype none
module ptalm_tick_gen #(
  parameter int unsigned OSC_DIV = ptalm_pkg::OSC_DIV_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire ptalm_pkg::ptalm_tick_cfg_t cfg_i,
  input wire logic minute_i,
  output logic tick_o
);
  logic [15:0] pre_r;
  logic [14:0] osc_r;
  logic osc_tick;
  logic [14:0] mask;
  logic raw;

  assign osc_tick = (pre_r == 16'(OSC_DIV - 1));

  always_comb begin
    mask = ptalm_pkg::OSC_PER_1;
    case (cfg_i.sel)
      ptalm_pkg::PTALM_SEL_4096: mask = ptalm_pkg::OSC_PER_4096;
      ptalm_pkg::PTALM_SEL_64: mask = ptalm_pkg::OSC_PER_64;
      default: mask = ptalm_pkg::OSC_PER_1;
    endcase
    // free-running divider, so 1 Hz is not tied to the seconds count
    raw = osc_tick && ((osc_r & mask) == mask);
    if (cfg_i.sel == ptalm_pkg::PTALM_SEL_MIN) begin
      raw = minute_i;
    end
    if (cfg_i.hold && (cfg_i.sel != ptalm_pkg::PTALM_SEL_4096)) begin
      raw = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_r <= 16'h0000;
      osc_r <= 15'h0000;
      tick_o <= 1'b0;
    end else begin
      pre_r <= osc_tick ? 16'h0000 : pre_r + 16'h0001;
      if (osc_tick) begin
        osc_r <= osc_r + 15'h0001;
      end
      tick_o <= raw;
    end
  end
endmodule : ptalm_tick_gen
`default_nettype wire

// File: hw/ptalm_top.sv
// Purpose: periodic countdown timer and alarm flag sharing one open-drain irq
// Assumes: AXI4-Lite slave on aclk; serial_clk and irq pin are asynchronous
// Notes: alarm_match and minute_update come from calendar logic on aclk
`timescale 1ns/1ps
`default_nettype none
module ptalm_top #(
  parameter int unsigned REL_FAST_CYC = ptalm_pkg::AUTO_REL_FAST_CYC,
  parameter int unsigned REL_SLOW_CYC = ptalm_pkg::AUTO_REL_SLOW_CYC,
  parameter int unsigned OSC_DIV = ptalm_pkg::OSC_DIV_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic serial_clk,
  input wire logic alarm_match,
  input wire logic minute_update,
  input wire logic irq_n_i,
  output logic irq_n_o,
  output logic irq_n_oe_n
);
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic aw_held;
    logic w_held;
    logic [5:0] aw_idx;
    logic [7:0] wbyte;
    logic wlane;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [11:0] preset;
    logic [11:0] count;
    logic timer_run;
    ptalm_pkg::ptalm_sel_t sel;
    logic [7:0] ext_keep;
    logic period_event_flag;
    logic alarm_hit_flag;
    logic period_int_enable;
    logic alarm_int_enable;
    logic halt;
    logic reset_bit;
    ptalm_pkg::ptalm_tstate_t tstate;
    logic tmr_low;
    logic alm_low;
    logic [31:0] rel_cnt;
    logic match_prev;
    logic irq_oe_n;
    logic pin_lvl;
  } ptalm_state_t;

  ptalm_state_t st_r;
  ptalm_state_t st_nxt;
  logic sclk_fall;
  logic irq_level;
  logic tick;
  ptalm_pkg::ptalm_tick_cfg_t tick_cfg;

  ptalm_sync u_sclk_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_i(serial_clk),
    .level_o(),
    .fall_o(sclk_fall)
  );

  ptalm_sync u_irq_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_i(irq_n_i),
    .level_o(irq_level),
    .fall_o()
  );

  assign tick_cfg.sel = st_r.sel;
  assign tick_cfg.hold = st_r.halt | st_r.reset_bit;

  ptalm_tick_gen #(
    .OSC_DIV(OSC_DIV)
  ) u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .cfg_i(tick_cfg),
    .minute_i(minute_update),
    .tick_o(tick)
  );

  function automatic logic [1:0] idx_resp(input logic [5:0] idx);
    logic [1:0] r;
    r = ptalm_pkg::RESP_SLVERR;
    if (idx >= ptalm_pkg::IDX_PRESET_LO && idx <= ptalm_pkg::IDX_AUX) begin
      r = ptalm_pkg::RESP_OKAY;
    end
    return r;
  endfunction : idx_resp

  function automatic logic [7:0] read_reg(input ptalm_state_t s, input logic [5:0] idx,
                                          input logic pin);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      ptalm_pkg::IDX_PRESET_LO: v = s.timer_run ? s.preset[7:0] : s.count[7:0];
      ptalm_pkg::IDX_PRESET_HI: v = {4'h0, s.timer_run ? s.preset[11:8] : s.count[11:8]};
      ptalm_pkg::IDX_EXT: begin
        v = s.ext_keep;
        v[ptalm_pkg::BIT_RUN] = s.timer_run;
        v[1:0] = s.sel;
      end
      ptalm_pkg::IDX_FLAG: begin
        v[ptalm_pkg::BIT_PEF] = s.period_event_flag;
        v[ptalm_pkg::BIT_AHF] = s.alarm_hit_flag;
      end
      ptalm_pkg::IDX_CTRL: begin
        v[ptalm_pkg::BIT_PIE] = s.period_int_enable;
        v[ptalm_pkg::BIT_AIE] = s.alarm_int_enable;
        v[ptalm_pkg::BIT_HALT] = s.halt;
      end
      ptalm_pkg::IDX_AUX: begin
        v[ptalm_pkg::BIT_RESET] = s.reset_bit;
        v[ptalm_pkg::BIT_PIN] = pin;
      end
      default: v = 8'h00;
    endcase
    return v;
  endfunction : read_reg

  always_comb begin
    logic wr_fire;
    logic [7:0] wd;
    logic period_event;
    logic match_rise;
    logic [31:0] rel_last;
    wr_fire = 1'b0;
    wd = 8'h00;
    period_event = 1'b0;
    match_rise = 1'b0;
    rel_last = 32'h0000_0000;
    st_nxt = st_r;

    // write address and data may arrive in either order
    if (s_axi_awvalid && st_r.awready) begin
      st_nxt.aw_held = 1'b1;
      st_nxt.aw_idx = s_axi_awaddr[7:2];
      st_nxt.awready = 1'b0;
    end
    if (s_axi_wvalid && st_r.wready) begin
      st_nxt.w_held = 1'b1;
      st_nxt.wbyte = s_axi_wdata[7:0];
      st_nxt.wlane = s_axi_wstrb[0];
      st_nxt.wready = 1'b0;
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
      st_nxt.awready = 1'b1;
      st_nxt.wready = 1'b1;
    end
    wr_fire = st_r.aw_held && st_r.w_held && !st_r.bvalid;
    wd = st_r.wbyte;
    if (wr_fire) begin
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = idx_resp(st_r.aw_idx);
    end

    if (wr_fire && st_r.wlane) begin
      case (st_r.aw_idx)
        ptalm_pkg::IDX_PRESET_LO: begin
          st_nxt.preset[7:0] = wd;
          if (!st_r.timer_run) begin
            st_nxt.count[7:0] = wd;
          end
        end
        ptalm_pkg::IDX_PRESET_HI: begin
          st_nxt.preset[11:8] = wd[3:0];
          if (!st_r.timer_run) begin
            st_nxt.count[11:8] = wd[3:0];
          end
        end
        ptalm_pkg::IDX_EXT: begin
          st_nxt.sel = ptalm_pkg::ptalm_sel_t'(wd[1:0]);
          st_nxt.ext_keep = wd & ptalm_pkg::EXT_KEEP_MASK;
          st_nxt.timer_run = wd[ptalm_pkg::BIT_RUN];
          if (wd[ptalm_pkg::BIT_RUN] && !st_r.timer_run) begin
            st_nxt.tstate = ptalm_pkg::PTALM_ST_ARMED;
          end else if (!wd[ptalm_pkg::BIT_RUN]) begin
            st_nxt.tstate = ptalm_pkg::PTALM_ST_IDLE;
          end
        end
        ptalm_pkg::IDX_FLAG: begin
          // a one written to a flag is ignored
          if (!wd[ptalm_pkg::BIT_PEF]) begin
            st_nxt.period_event_flag = 1'b0;
          end
          if (!wd[ptalm_pkg::BIT_AHF]) begin
            st_nxt.alarm_hit_flag = 1'b0;
          end
        end
        ptalm_pkg::IDX_CTRL: begin
          st_nxt.period_int_enable = wd[ptalm_pkg::BIT_PIE];
          st_nxt.alarm_int_enable = wd[ptalm_pkg::BIT_AIE];
          st_nxt.halt = wd[ptalm_pkg::BIT_HALT];
        end
        ptalm_pkg::IDX_AUX: st_nxt.reset_bit = wd[ptalm_pkg::BIT_RESET];
        default: st_nxt.reset_bit = st_r.reset_bit;
      endcase
    end

    // read channel: one read in flight, data from a register
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
      st_nxt.arready = 1'b1;
    end
    if (s_axi_arvalid && st_r.arready) begin
      st_nxt.arready = 1'b0;
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = idx_resp(s_axi_araddr[7:2]);
      st_nxt.rdata = {24'h000000, read_reg(st_r, s_axi_araddr[7:2], irq_level)};
    end

    // countdown; the live count is not frozen while it is read
    case (st_r.tstate)
      ptalm_pkg::PTALM_ST_IDLE: begin
        // stopped: count holds, so a read sees a steady live value
        st_nxt.tstate = st_nxt.tstate;
      end
      ptalm_pkg::PTALM_ST_ARMED: begin
        if (sclk_fall && st_nxt.tstate == ptalm_pkg::PTALM_ST_ARMED) begin
          st_nxt.count = st_r.preset;
          st_nxt.tstate = ptalm_pkg::PTALM_ST_RUN;
        end
      end
      ptalm_pkg::PTALM_ST_RUN: begin
        // tick phase is free-running, so the first interval may be short
        if (tick && st_nxt.tstate == ptalm_pkg::PTALM_ST_RUN) begin
          if (st_r.count <= 12'h001) begin
            period_event = 1'b1;
            st_nxt.count = st_r.preset;
          end else begin
            st_nxt.count = st_r.count - 12'h001;
          end
        end
      end
      default: st_nxt.tstate = ptalm_pkg::PTALM_ST_IDLE;
    endcase

    // hardware set wins over a software clear in the same cycle
    if (period_event) begin
      st_nxt.period_event_flag = 1'b1;
    end

    rel_last = (st_r.sel == ptalm_pkg::PTALM_SEL_4096) ? 32'(REL_FAST_CYC - 1)
                                                       : 32'(REL_SLOW_CYC - 1);
    if (st_r.tmr_low) begin
      // clearing the run bit or the flag leaves this alone
      if (st_r.rel_cnt >= rel_last) begin
        st_nxt.tmr_low = 1'b0;
      end else begin
        st_nxt.rel_cnt = st_r.rel_cnt + 32'h0000_0001;
      end
    end
    if (period_event && st_nxt.period_int_enable) begin
      st_nxt.tmr_low = 1'b1;
      st_nxt.rel_cnt = 32'h0000_0000;
    end
    if (!st_nxt.period_int_enable) begin
      st_nxt.tmr_low = 1'b0;
    end

    // only a fresh entry into the match counts as an alarm
    st_nxt.match_prev = alarm_match;
    match_rise = alarm_match && !st_r.match_prev;
    if (match_rise) begin
      st_nxt.alarm_hit_flag = 1'b1;
      if (st_nxt.alarm_int_enable) begin
        st_nxt.alm_low = 1'b1;
      end
    end
    if (!st_nxt.alarm_int_enable) begin
      st_nxt.alm_low = 1'b0;
    end
    if (!st_nxt.alarm_hit_flag) begin
      st_nxt.alm_low = 1'b0;
    end

    // wired sources: either one holds the pin low
    // each source keeps its own flop, so releasing one never frees the other
    st_nxt.irq_oe_n = 1'b1;
    if (st_nxt.tmr_low) begin
      st_nxt.irq_oe_n = 1'b0;
    end
    if (st_nxt.alm_low) begin
      st_nxt.irq_oe_n = 1'b0;
    end
    // the pin data never leaves low; only the enable moves
    st_nxt.pin_lvl = 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      st_r.awready <= 1'b1;
      st_r.wready <= 1'b1;
      st_r.arready <= 1'b1;
      st_r.preset <= ptalm_pkg::PRESET_RST;
      st_r.count <= ptalm_pkg::PRESET_RST;
      st_r.tstate <= ptalm_pkg::PTALM_ST_IDLE;
      st_r.irq_oe_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign s_axi_awready = st_r.awready;
  assign s_axi_wready = st_r.wready;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rresp = st_r.rresp;
  assign s_axi_rdata = st_r.rdata;
  assign irq_n_oe_n = st_r.irq_oe_n;
  // driven level is always low; the enable alone makes it open drain
  assign irq_n_o = st_r.pin_lvl;
endmodule : ptalm_top
`default_nettype wire

// File: shared/ptalm_pkg.sv
// Purpose: constants and types shared by the periodic timer and alarm irq block
// Assumes: 200 MHz aclk, registers reached over AXI4-Lite, one word per register
// Notes: Operation list below; byte address of a register is four times its index
//
// Operation
// - tick select 00=4096 Hz, 01=64 Hz, 10=1 Hz, 11=1/60 Hz drives countdown.
// - timer low on irq auto-releases after 122 us at 4096 Hz, else 7.813 ms.
// - halt or reset bit suspends 64 Hz, 1 Hz, 1/60 Hz ticks, not 4096 Hz.
// - 12-bit preset 1..4095; low byte in one register, high nibble in next.
// - count decrements per tick; one-to-zero step is an event setting the flag.
// - after each event the preset reloads and counting continues.
// - enable rising from zero to one restarts from the preset.
// - counter read gives preset while enabled, live unfrozen count while disabled.
// - counter registers are plain storage when timer and its irq are off.
// - clearing enable stops the timer but leaves a low irq alone.
// - event flag sticks until written zero; writing one does nothing.
// - clearing the event flag does not release a timer low on irq.
// - timer irq enable gates the low level; clearing it releases timer low.
// - irq is shared; one source disabled never blocks the other.
// - countdown starts at first serial clock fall after the enabling write.
// - 1/60 Hz ticks follow calendar minute updates; 1 Hz runs on its own.
// - first interval may be one tick short of tick period times preset.
// - alarm fires only on a fresh count into the match, then sets its flag.
// - alarm low never auto-releases; held until flag or enable cleared.
// - alarm enable falling releases an alarm low at once.
// - alarm flag cleared releases an alarm low at once.
// - match with alarm enable off still sets the flag, irq stays released.
// - timer low lasts only the release time; next event drives it again.
`default_nettype none
package ptalm_pkg;
  localparam int unsigned ADDR_W = 8;
  // register indices; byte address is index times four
  localparam logic [5:0] IDX_PRESET_LO = 6'h0B;
  localparam logic [5:0] IDX_PRESET_HI = 6'h0C;
  localparam logic [5:0] IDX_EXT = 6'h0D;
  localparam logic [5:0] IDX_FLAG = 6'h0E;
  localparam logic [5:0] IDX_CTRL = 6'h0F;
  localparam logic [5:0] IDX_AUX = 6'h10;
  // field positions
  localparam int unsigned BIT_RUN = 4;
  localparam int unsigned BIT_PEF = 4;
  localparam int unsigned BIT_AHF = 3;
  localparam int unsigned BIT_PIE = 4;
  localparam int unsigned BIT_AIE = 3;
  localparam int unsigned BIT_HALT = 1;
  localparam int unsigned BIT_RESET = 0;
  localparam int unsigned BIT_PIN = 1;
  localparam logic [7:0] EXT_KEEP_MASK = 8'h4C;
  localparam logic [11:0] PRESET_RST = 12'h000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // timing
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned CLK_HZ = 200000000;
  localparam int unsigned OSC_HZ = 32768;
  localparam int unsigned OSC_DIV_CYC = CLK_HZ / OSC_HZ;
  localparam int unsigned AUTO_REL_FAST_NS = 122000;
  localparam int unsigned AUTO_REL_SLOW_NS = 7813000;
  // divide first: the slow time in ps would overflow 32 bits
  localparam int unsigned AUTO_REL_FAST_CYC = AUTO_REL_FAST_NS / (CLK_PERIOD_PS / 1000);
  localparam int unsigned AUTO_REL_SLOW_CYC = AUTO_REL_SLOW_NS / (CLK_PERIOD_PS / 1000);
  // tick masks: oscillator cycles per tick minus one
  localparam logic [14:0] OSC_PER_4096 = 15'h0007;
  localparam logic [14:0] OSC_PER_64 = 15'h01FF;
  localparam logic [14:0] OSC_PER_1 = 15'h7FFF;

  typedef enum logic [1:0] {
    PTALM_SEL_4096 = 2'h0,
    PTALM_SEL_64 = 2'h1,
    PTALM_SEL_1 = 2'h2,
    PTALM_SEL_MIN = 2'h3
  } ptalm_sel_t;

  typedef enum logic [2:0] {
    PTALM_ST_IDLE = 3'h1,
    PTALM_ST_ARMED = 3'h2,
    PTALM_ST_RUN = 3'h4
  } ptalm_tstate_t;

  typedef struct packed {
    ptalm_sel_t sel;
    logic hold;
  } ptalm_tick_cfg_t;
endpackage : ptalm_pkg
`default_nettype wire

// File: testbench/ptalm_chk.sv
// Purpose: port checks for ptalm_top
// Assumes: one aclk domain, aresetn sync active low
// Notes: timer lows are bounded only while alarm_match is low
`timescale 1ns/1ps
`default_nettype none
module ptalm_chk #(
  parameter int unsigned REL_SLOW_CYC = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic alarm_match,
  input wire logic irq_n_o,
  input wire logic irq_n_oe_n
);
  logic [31:0] low_cnt_r;
  logic [31:0] low_cnt_nxt;
  logic map_rd;
  assign map_rd = s_axi_araddr[7:2] >= 6'h0B && s_axi_araddr[7:2] <= 6'h10;
  // an alarm may hold the pin, so the count restarts while it matches
  always_comb begin
    low_cnt_nxt = (irq_n_oe_n || alarm_match) ? 32'h0 : low_cnt_r + 32'h1;
  end
  always_ff @(posedge aclk) begin
    low_cnt_r <= aresetn ? low_cnt_nxt : 32'h0;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence aw_take; s_axi_awvalid && s_axi_awready; endsequence
  sequence w_take; s_axi_wvalid && s_axi_wready; endsequence
  sequence b_take; s_axi_bvalid && s_axi_bready; endsequence
  sequence ar_take; s_axi_arvalid && s_axi_arready; endsequence
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  b_timing_a: assert property ((aw_take and w_take) |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not two cycles after take");
  aw_block_a: assert property (!s_axi_awready && !s_axi_bvalid |=> !s_axi_awready)
    else $error("second write address accepted");
  b_done_a: assert property (b_take |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write channels not reopened after response");
  r_timing_a: assert property (ar_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer not one cycle after take");
  unmapped_rd_a: assert property (ar_take and !map_rd |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  mapped_rd_a: assert property (ar_take and map_rd |=> s_axi_rresp == 2'h0 && s_axi_rdata[31:8] == 24'h0)
    else $error("mapped read bad response");
  pin_zero_a: assert property (irq_n_o == 1'b0)
    else $error("irq pin data not low");
  timer_rel_a: assert property (low_cnt_r <= REL_SLOW_CYC)
    else $error("timer low held too long");
endmodule : ptalm_chk
bind ptalm_top ptalm_chk #(.REL_SLOW_CYC(REL_SLOW_CYC)) chk (.*);
`default_nettype wire

// File: testbench/ptalm_link.sv
// Purpose: far-side serial clock frames
// Assumes: idle low between frames, 64 ns period
// Notes: only the clock is modelled, frame data is not needed here
`timescale 1ns/1ps
`default_nettype none
module ptalm_link (
  input wire logic go,
  output logic serial_clk
);
  initial serial_clk = 1'b0;
  // frame carrying the enabling write; its first fall starts the count
  always @(posedge go) begin
    repeat (8) begin
      #32 serial_clk = 1'b1;
      #32 serial_clk = 1'b0;
    end
  end
endmodule : ptalm_link
`default_nettype wire

// File: testbench/ptalm_top_test.sv
// Purpose: self-checking bench for ptalm_top
// Assumes: short release and prescale parameters
// Notes: table covers plain register access, timer and alarm cases follow
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, a, e); end end
module ptalm_top_test;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e; logic [1:0] r;} ptalm_row_t;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic alarm_match = 1'b0, minute_update = 1'b0, go = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic serial_clk, irq_n_o, irq_n_oe_n, irq_n_i;
  logic [1:0] r;
  logic [31:0] q;
  logic [31:0] q0;
  bit ok;
  int n;
  int error_cnt = 0;
  int checks = 0;
  ptalm_row_t rows [6] = '{'{8'h2C, 8'hA5, 8'hA5, 2'h0}, '{8'h30, 8'hFF, 8'h0F, 2'h0},
    '{8'h34, 8'h4C, 8'h4C, 2'h0}, '{8'h3C, 8'h02, 8'h02, 2'h0},
    '{8'h38, 8'hFF, 8'h00, 2'h0}, '{8'h08, 8'h11, 8'h00, 2'h2}};
  assign irq_n_i = (irq_n_oe_n === 1'b0) ? 1'b0 : 1'b1;
  always #2.5 aclk = ~aclk;
  ptalm_top #(.REL_FAST_CYC(8), .REL_SLOW_CYC(32), .OSC_DIV(4)) dut (.*);
  ptalm_link link (.go(go), .serial_clk(serial_clk));
  task automatic conclude();
    if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int k = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && k < 40);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (k >= 40) begin error_cnt++; conclude(); end
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int k = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && k < 40);
    q = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (k >= 40) begin error_cnt++; conclude(); end
  endtask : rd
  // ok tells whether the pin reached lvl within lim cycles
  task automatic wt(input logic lvl, input int lim);
    int k = 0;
    ok = 0;
    while (!ok && k < lim) begin
      @(posedge aclk);
      k++;
      ok = (irq_n_oe_n === lvl);
    end
  endtask : wt
  task automatic frame();
    @(posedge aclk);
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
  endtask : frame
  // one-cycle calendar minute pulse, then a short gap
  task automatic minute();
    @(posedge aclk);
    minute_update <= 1'b1;
    @(posedge aclk);
    minute_update <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask : minute
  initial begin
    #100000;
    error_cnt++;
    conclude();
  end
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(8'h2C + 8'(4 * i));
      `CHK(q, (i == 5) ? 32'h2 : 32'h0)
    end
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      `CHK(r, rows[i].r)
      rd(rows[i].a);
      `CHK(q, {24'h0, rows[i].e})
      `CHK(r, rows[i].r)
    end
    // 4096 Hz: count starts at the serial clock fall, 8-cycle low, preset read while running
    wr(8'h3C, 8'h10);
    wr(8'h30, 8'h00);
    wr(8'h2C, 8'h03);
    wr(8'h34, 8'h10);
    wt(1'b0, 150);
    `CHK(ok, 1'b0)
    frame();
    wt(1'b0, 300);
    `CHK(ok, 1'b1)
    n = 0;
    while (irq_n_oe_n === 1'b0 && n < 100) begin @(posedge aclk); n++; end
    `CHK(n, 8)
    wt(1'b0, 200);
    `CHK(ok, 1'b1)
    rd(8'h2C);
    `CHK(q, 32'h3)
    rd(8'h38);
    `CHK(q, 32'h10)
    // stop order: run, flag, then new settings
    wr(8'h34, 8'h00);
    wr(8'h38, 8'h00);
    wr(8'h2C, 8'h01);
    wr(8'h34, 8'h11);
    frame();
    wt(1'b0, 3000);
    `CHK(ok, 1'b1)
    wr(8'h38, 8'h00);
    `CHK(irq_n_oe_n, 1'b0)
    wr(8'h34, 8'h01);
    `CHK(irq_n_oe_n, 1'b0)
    wr(8'h3C, 8'h00);
    repeat (2) @(posedge aclk);
    `CHK(irq_n_oe_n, 1'b1)
    wr(8'h3C, 8'h02);
    wr(8'h38, 8'h00);
    wr(8'h34, 8'h11);
    frame();
    repeat (2600) @(posedge aclk);
    rd(8'h38);
    `CHK(q, 32'h0)
    wr(8'h34, 8'h10);
    repeat (100) @(posedge aclk);
    rd(8'h38);
    `CHK(q, 32'h10)
    wr(8'h34, 8'h00);
    wr(8'h38, 8'h00);
    wr(8'h3C, 8'h08);
    alarm_match <= 1'b1;
    repeat (40) @(posedge aclk);
    `CHK(irq_n_oe_n, 1'b0)
    rd(8'h38);
    `CHK(q, 32'h08)
    wr(8'h38, 8'h00);
    repeat (2) @(posedge aclk);
    `CHK(irq_n_oe_n, 1'b1)
    alarm_match <= 1'b0;
    @(posedge aclk);
    alarm_match <= 1'b1;
    repeat (3) @(posedge aclk);
    `CHK(irq_n_oe_n, 1'b0)
    wr(8'h3C, 8'h00);
    repeat (2) @(posedge aclk);
    `CHK(irq_n_oe_n, 1'b1)
    wr(8'h38, 8'h00);
    alarm_match <= 1'b0;
    @(posedge aclk);
    alarm_match <= 1'b1;
    repeat (5) @(posedge aclk);
    `CHK(irq_n_oe_n, 1'b1)
    rd(8'h38);
    `CHK(q, 32'h08)
    alarm_match <= 1'b0;
    // minute source; the reset bit holds it back first
    wr(8'h38, 8'h00);
    wr(8'h2C, 8'h03);
    wr(8'h40, 8'h01);
    wr(8'h34, 8'h13);
    frame();
    repeat (30) @(posedge aclk);
    repeat (3) minute();
    rd(8'h38);
    `CHK(q, 32'h0)
    wr(8'h40, 8'h00);
    repeat (3) minute();
    rd(8'h38);
    `CHK(q, 32'h10)
    minute();
    wr(8'h34, 8'h03);
    // live count is not held for the read, so take two that agree
    n = 0;
    q = 32'hFFFF_FFFF;
    do begin
      q0 = q;
      rd(8'h2C);
      n++;
    end while (q !== q0 && n < 4);
    `CHK(q0, q)
    `CHK(q, 32'h2)
    // mid-run reset while the alarm holds the pin low
    wr(8'h3C, 8'h08);
    alarm_match <= 1'b1;
    repeat (3) @(posedge aclk);
    `CHK(irq_n_oe_n, 1'b0)
    aresetn <= 1'b0;
    alarm_match <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    `CHK(irq_n_oe_n, 1'b1)
    rd(8'h3C);
    `CHK(q, 32'h0)
    rd(8'h2C);
    `CHK(q, 32'h0)
    conclude();
  end
endmodule : ptalm_top_test
`default_nettype wire
